// >>> acp_defines.svh
// Register offsets, field positions and timing counts of the computation unit
`ifndef ACP_DEFINES_SVH
`define ACP_DEFINES_SVH
// Register byte offsets
`define ACP_OFF_CTRL  8'h00
`define ACP_OFF_RPT   8'h04
`define ACP_OFF_THR   8'h08
`define ACP_OFF_STAT  8'h0C
`define ACP_OFF_ACC   8'h10
`define ACP_OFF_FILT  8'h14
`define ACP_OFF_RES   8'h18
`define ACP_OFF_ISTS  8'h1C
`define ACP_OFF_IMSK  8'h20
// Control register fields
`define ACP_MODE_LSB  0
`define ACP_DOUBLE_SAMPLE_ENABLE_BIT  3
`define ACP_CLR_BIT   4
`define ACP_SHIFT_LSB 5
`define ACP_PUMP_BIT  8
// Interrupt status bits
`define ACP_IRQ_DONE  0
`define ACP_IRQ_THR   1
// Counter saturation value
`define ACP_CNT_MAX   8'hFF
// Cycles spent on an accumulator clear
`define ACP_CLR_CYC   2'd3
// Clock period and pump start-up time
`define ACP_CLK_NS    100
`define ACP_PUMP_NS   10000
`define ACP_PUMP_CYC  ((`ACP_PUMP_NS + `ACP_CLK_NS - 1) / `ACP_CLK_NS)
`endif

// >>> acp_pkg.sv
// Types of the post-conversion computation unit
package acp_pkg;
  // Computation modes, in code order 0 to 4
  typedef enum logic [2:0] {
    ACP_BASIC, ACP_ACCUM, ACP_AVG, ACP_BURST, ACP_LPF
  } acp_mode_t;

  // Conversion strobe with its result
  typedef struct packed {
    logic        valid;
    logic [11:0] data;
  } acp_conv_t;

  // Requests back to the converter core
  typedef struct packed {
    logic retrig;
    logic stop;
  } acp_trig_t;

  // Whole state of the unit
  typedef struct packed {
    acp_mode_t   mode;
    logic        double_sample_enable;
    logic [2:0]  shift;
    logic        pump_en;
    logic        clr;
    logic [1:0]  clr_cnt;
    logic [7:0]  repeat_field;
    logic [17:0] thr;
    logic [17:0] acc;
    logic [7:0]  cnt;
    logic [17:0] filt;
    logic        ovf;
    logic        phase;
    logic [11:0] prev;
    logic [11:0] cur;
    logic [15:0] pump_cnt;
    logic        pump_rdy;
    logic [1:0]  ists;
    logic [1:0]  imask;
    logic        aw_v;
    logic [7:0]  aw_a;
    logic        w_v;
    logic [31:0] w_d;
    logic [3:0]  w_s;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    acp_trig_t   trig;
  } acp_state_t;
endpackage : acp_pkg

// >>> acp_core.sv
// Post-conversion computation unit with AXI4-Lite registers
// Behaviour
// - A mode field selects basic, accumulate, average, burst average or filter, codes 0 to 4.
// - Basic mode leaves accumulator and counter alone and tests the threshold on every sample.
// - Accumulate mode adds each sample and counts up, the counter holding at 0xFF.
// - The conversion-done flag is set after every conversion.
// - Average mode tests once the count reaches the target and clears at the next start then.
// - Burst mode clears at each start and retriggers until the count equals the target.
// - Filter mode adds the sample and subtracts the accumulator shifted right by the shift.
// - The filter output is the accumulator shifted right by the shift setting.
// - With double sampling a cycle spans two conversions and their difference is used.
// - The accumulator is 18 bits and an overflow flag is set when the sum leaves that range.
// - A clear command empties accumulator, overflow and counter, then drops by itself.
// - The clear finishes within five clock cycles.
// - In filter mode the shift setting sets the cutoff frequency.
// - A true threshold condition raises the threshold flag and asks the core to stop.
// - The pump ready bit rises only after the pump start-up time with the pump enabled.
// - A set overflow flag raises the threshold flag at every computation.
`include "acp_defines.svh"
module acp_core #(
  parameter int PUMP_CYC = `ACP_PUMP_CYC
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire acp_pkg::acp_conv_t conv,
  input  wire logic              start_evt,
  output acp_pkg::acp_trig_t     trig,
  output logic [17:0]            accumulator_value,
  output logic [7:0]             sample_counter,
  output logic [17:0]            filter_output,
  output logic                   pump_enable,
  output logic                   pump_ready,
  output logic                   irq
);

  acp_pkg::acp_state_t s;
  acp_pkg::acp_state_t n;
  logic [32:0] rd;
  logic [32:0] ra;
  logic [31:0] wv;
  logic [12:0] dif;
  logic [18:0] smp;
  logic [18:0] sum;
  logic [17:0] a0;
  logic [17:0] fv;
  logic [17:0] tv;
  logic [7:0]  c0;
  logic [7:0]  cn;
  logic        go;
  logic        test;

  // Right shift by the shift setting
  function automatic logic [17:0] shr(input logic [17:0] v, input logic [2:0] k);
    shr = v >> k;
  endfunction : shr

  // Byte-lane merge of write data into the old word
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] b);
    merge = o;
    for (int i = 0; i < 4; i++) begin
      if (b[i]) begin
        merge[i*8 +: 8] = d[i*8 +: 8];
      end
    end
  endfunction : merge

  // Register read decode; top bit marks a mapped address
  function automatic logic [32:0] rd_word(input acp_pkg::acp_state_t st,
                                          input logic [7:0] a);
    rd_word = {1'b1, 32'h0000_0000};
    case ({a[7:2], 2'b00})
      `ACP_OFF_CTRL: rd_word[31:0] = {23'h0, st.pump_en, st.shift, st.clr, st.double_sample_enable, st.mode};
      `ACP_OFF_RPT:  rd_word[7:0]  = st.repeat_field;
      `ACP_OFF_THR:  rd_word[17:0] = st.thr;
      `ACP_OFF_STAT: rd_word[31:0] = {16'h0, st.cnt, 5'h0, st.clr, st.pump_rdy, st.ovf};
      `ACP_OFF_ACC:  rd_word[17:0] = st.acc;
      `ACP_OFF_FILT: rd_word[17:0] = st.filt;
      `ACP_OFF_RES:  rd_word[31:0] = {4'h0, st.prev, 4'h0, st.cur};
      `ACP_OFF_ISTS: rd_word[1:0]  = st.ists;
      `ACP_OFF_IMSK: rd_word[1:0]  = st.imask;
      default:       rd_word[32]   = 1'b0;
    endcase
  endfunction : rd_word

  // Next-state logic: bus slave, computation, clear and pump
  always_comb begin
    n      = s;
    n.trig = '0;
    rd     = rd_word(s, s.aw_a);
    ra     = rd_word(s, s_axi_araddr);
    wv     = merge(rd[31:0], s.w_d, s.w_s);

    // Write address and data are taken in either order
    if (s_axi_awvalid && !s.aw_v) begin
      n.aw_v = 1'b1;
      n.aw_a = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s.w_v) begin
      n.w_v = 1'b1;
      n.w_d = s_axi_wdata;
      n.w_s = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (s.aw_v && s.w_v && !s.bvalid) begin
      n.aw_v   = 1'b0;
      n.w_v    = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = rd[32] ? 2'h0 : 2'h2;
      case ({s.aw_a[7:2], 2'b00})
        `ACP_OFF_CTRL: begin
          n.mode    = acp_pkg::acp_mode_t'(wv[`ACP_MODE_LSB +: 3]);
          n.double_sample_enable    = wv[`ACP_DOUBLE_SAMPLE_ENABLE_BIT];
          n.shift   = wv[`ACP_SHIFT_LSB +: 3];
          n.pump_en = wv[`ACP_PUMP_BIT];
          if (wv[`ACP_CLR_BIT] && !s.clr) begin
            n.clr     = 1'b1;
            n.clr_cnt = 2'd0;
          end
        end
        `ACP_OFF_RPT:  n.repeat_field   = wv[7:0];
        `ACP_OFF_THR:  n.thr   = wv[17:0];
        `ACP_OFF_ISTS: n.ists  = s.ists & ~wv[1:0];
        `ACP_OFF_IMSK: n.imask = wv[1:0];
        default: ;
      endcase
    end

    // Read channel, one read under way at a time
    if (s.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !s.rvalid) begin
      n.rvalid = 1'b1;
      n.rdata  = ra[31:0];
      n.rresp  = ra[32] ? 2'h0 : 2'h2;
    end

    // Start clears the running sum in burst mode, and in average mode once the count reached the target
    a0 = s.acc;
    c0 = s.cnt;
    if (start_evt && ((s.mode == acp_pkg::ACP_AVG && s.cnt >= s.repeat_field) ||
                      s.mode == acp_pkg::ACP_BURST)) begin
      a0      = 18'h0_0000;
      c0      = 8'h00;
      n.acc   = a0;
      n.cnt   = c0;
      n.filt  = 18'h0_0000;
      n.phase = 1'b0;
    end

    // Sample is the result, or second minus first when double sampling
    dif = {1'b0, conv.data} - {1'b0, s.cur};
    smp = s.double_sample_enable ? {{6{dif[12]}}, dif} : {7'h00, conv.data};
    cn  = (c0 == `ACP_CNT_MAX) ? c0 : c0 + 8'h01;
    sum = {1'b0, a0} + smp;
    if (s.mode == acp_pkg::ACP_LPF) begin
      sum = sum - {1'b0, shr(a0, s.shift)};
    end
    fv   = shr(sum[17:0], s.shift);
    go   = conv.valid && !(s.double_sample_enable && !s.phase);
    test = 1'b0;
    tv   = smp[17:0];

    // Every conversion stores the result and flags completion
    if (conv.valid) begin
      n.cur   = conv.data;
      n.prev  = s.cur;
      n.phase = s.double_sample_enable && !s.phase;
      n.ists[`ACP_IRQ_DONE] = 1'b1;
    end

    // Computation at the end of each cycle
    if (go) begin
      case (s.mode)
        acp_pkg::ACP_ACCUM, acp_pkg::ACP_AVG, acp_pkg::ACP_BURST, acp_pkg::ACP_LPF: begin
          n.acc  = sum[17:0];
          n.cnt  = cn;
          n.filt = fv;
          n.ovf  = s.ovf | sum[18];
          test   = (s.mode == acp_pkg::ACP_ACCUM) || (cn >= s.repeat_field);
          tv     = fv;
        end
        default: begin
          test = 1'b1;
          tv   = smp[17:0];
        end
      endcase
      if ((test && tv >= s.thr) || n.ovf) begin
        n.ists[`ACP_IRQ_THR] = 1'b1;
        n.trig.stop          = 1'b1;
      end
      if (s.mode == acp_pkg::ACP_BURST && cn < s.repeat_field) begin
        n.trig.retrig = 1'b1;
      end
    end

    // Clear command runs a fixed number of cycles, then drops itself
    if (s.clr) begin
      if (s.clr_cnt == `ACP_CLR_CYC - 2'd1) begin
        n.acc   = 18'h0_0000;
        n.cnt   = 8'h00;
        n.ovf   = 1'b0;
        n.filt  = 18'h0_0000;
        n.phase = 1'b0;
        n.clr   = 1'b0;
      end else begin
        n.clr_cnt = s.clr_cnt + 2'd1;
      end
    end

    // Pump start-up timer
    if (!s.pump_en) begin
      n.pump_cnt = 16'h0000;
      n.pump_rdy = 1'b0;
    end else if (s.pump_cnt == 16'(PUMP_CYC - 1)) begin
      n.pump_rdy = 1'b1;
    end else begin
      n.pump_cnt = s.pump_cnt + 16'h0001;
    end
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // Port drive
  assign s_axi_awready     = !s.aw_v;
  assign s_axi_wready      = !s.w_v;
  assign s_axi_bvalid      = s.bvalid;
  assign s_axi_bresp       = s.bresp;
  assign s_axi_arready     = !s.rvalid;
  assign s_axi_rvalid      = s.rvalid;
  assign s_axi_rdata       = s.rdata;
  assign s_axi_rresp       = s.rresp;
  assign trig              = s.trig;
  assign accumulator_value = s.acc;
  assign sample_counter    = s.cnt;
  assign filter_output     = s.filt;
  assign pump_enable       = s.pump_en;
  assign pump_ready        = s.pump_rdy;
  assign irq               = |(s.ists & s.imask);

  // Checks on the computation and control state
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_clr_req;
    $rose(s.clr);
  endsequence

  sequence s_clr_done;
    !s.clr && s.cnt == 8'h00 && !s.ovf && s.acc == 18'h0_0000;
  endsequence

  AST_BASIC_HOLD: assert property (
    conv.valid && s.mode == acp_pkg::ACP_BASIC && !s.clr && !start_evt
    |=> s.acc == $past(s.acc) && s.cnt == $past(s.cnt))
    else $error("basic mode changed the accumulator");

  AST_CNT_SAT: assert property (
    conv.valid && !s.double_sample_enable && s.mode == acp_pkg::ACP_ACCUM && s.cnt == 8'hFF && !s.clr
    |=> s.cnt == 8'hFF)
    else $error("sample counter wrapped");

  AST_DONE: assert property (
    conv.valid |=> s.ists[`ACP_IRQ_DONE])
    else $error("conversion done flag not set");

  AST_AVG_CLR: assert property (
    start_evt && !conv.valid && s.mode == acp_pkg::ACP_AVG && s.cnt >= s.repeat_field && !s.clr
    |=> s.cnt == 8'h00 && s.acc == 18'h0_0000)
    else $error("average mode did not clear at start");

  AST_BURST_RETRIG: assert property (
    conv.valid && !s.double_sample_enable && s.mode == acp_pkg::ACP_BURST && !start_evt &&
    s.cnt == 8'h00 && s.repeat_field > 8'h01
    |=> s.trig.retrig ##1 !s.trig.retrig)
    else $error("burst mode did not retrigger");

  AST_OVF_IRQ: assert property (
    $rose(s.ovf) |-> s.ists[`ACP_IRQ_THR] && $past(s.trig.stop) == 1'b0 && s.trig.stop)
    else $error("overflow without threshold flag");

  AST_CLR: assert property (
    s_clr_req |-> s.clr [*3] ##1 s_clr_done)
    else $error("clear command did not finish in time");

  AST_CLR_BOUND: assert property (
    s_clr_req |-> ##[1:5] !s.clr)
    else $error("clear command too slow");

  AST_PUMP: assert property (
    $rose(s.pump_rdy) |-> $past(s.pump_cnt) == 16'(PUMP_CYC - 1) && $past(s.pump_en))
    else $error("pump ready too early");

  AST_CNT_STEP: assert property (
    conv.valid && !s.double_sample_enable && s.mode == acp_pkg::ACP_ACCUM && !s.clr && s.cnt != 8'hFF
    |=> s.cnt == $past(s.cnt) + 8'h01)
    else $error("sample counter did not advance");

  AST_AVG_EARLY: assert property (
    conv.valid && !s.double_sample_enable && s.mode == acp_pkg::ACP_AVG && !start_evt && !s.clr && !s.ovf &&
    {1'b0, s.cnt} + 9'h001 < {1'b0, s.repeat_field} && {1'b0, s.acc} + {7'h00, conv.data} <= 19'h3FFFF
    |=> !s.trig.stop)
    else $error("average mode tested before the target");

  AST_AVG_TEST: assert property (
    conv.valid && !s.double_sample_enable && s.mode == acp_pkg::ACP_AVG && !start_evt && !s.clr &&
    {1'b0, s.cnt} + 9'h001 >= {1'b0, s.repeat_field} &&
    (({1'b0, s.acc} + {7'h00, conv.data}) >> s.shift) >= {1'b0, s.thr}
    |=> s.trig.stop && s.ists[`ACP_IRQ_THR])
    else $error("average mode missed the threshold");

  AST_BURST_END: assert property (
    conv.valid && !s.double_sample_enable && s.mode == acp_pkg::ACP_BURST && !start_evt && !s.clr &&
    {1'b0, s.cnt} + 9'h001 == {1'b0, s.repeat_field}
    |=> !s.trig.retrig && s.cnt == $past(s.repeat_field))
    else $error("burst did not end at the target");

  AST_LPF_STEP: assert property (
    conv.valid && !s.double_sample_enable && s.mode == acp_pkg::ACP_LPF && !s.clr
    |=> s.acc == $past(s.acc) + $past(conv.data) - ($past(s.acc) >> $past(s.shift)))
    else $error("filter step wrong");

  AST_FILT: assert property (
    conv.valid && !s.double_sample_enable && !s.clr &&
    s.mode inside {acp_pkg::ACP_ACCUM, acp_pkg::ACP_AVG, acp_pkg::ACP_BURST, acp_pkg::ACP_LPF}
    |=> s.filt == s.acc >> $past(s.shift))
    else $error("filter output is not the shifted accumulator");

  AST_DS_FIRST: assert property (
    conv.valid && s.double_sample_enable && !s.phase && !s.clr && !start_evt
    |=> s.acc == $past(s.acc) && s.cnt == $past(s.cnt))
    else $error("first sample of a pair changed the sums");

  AST_DS_DIFF: assert property (
    conv.valid && s.double_sample_enable && s.phase && s.mode == acp_pkg::ACP_ACCUM && !s.clr
    |=> s.acc == $past(s.acc) + $past(conv.data) - $past(s.cur))
    else $error("double sample difference wrong");

  AST_OVF_SET: assert property (
    conv.valid && !s.double_sample_enable && !start_evt && !s.clr &&
    s.mode inside {acp_pkg::ACP_ACCUM, acp_pkg::ACP_AVG, acp_pkg::ACP_BURST} &&
    {1'b0, s.acc} + {7'h00, conv.data} > 19'h3FFFF
    |=> s.ovf)
    else $error("accumulator overflow not flagged");

  AST_THR_STOP: assert property (
    conv.valid && !s.double_sample_enable && s.mode == acp_pkg::ACP_BASIC && !s.clr &&
    {6'h00, conv.data} >= s.thr
    |=> s.trig.stop && s.ists[`ACP_IRQ_THR])
    else $error("threshold hit did not stop conversions");

  AST_PUMP_OFF: assert property (
    !s.pump_en |=> !s.pump_rdy)
    else $error("pump ready without enable");

endmodule : acp_core

// >>> acp_adc_model.sv
// Converter core model that answers start and retrigger requests
module acp_adc_model (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic               go,
  input  wire acp_pkg::acp_trig_t trig,
  input  wire logic [11:0]        sample,
  output acp_pkg::acp_conv_t      conv
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] pend_q;
  initial conv = '0;
  // Finish a conversion two cycles after a request, give up on a stop
  always @(posedge aclk) begin
    conv.valid <= 1'b0;
    conv.data  <= ~conv.data;
    if (!aresetn || trig.stop) begin
      pend_q <= 2'h0;
    end else if (go || trig.retrig) begin
      pend_q <= 2'h2;
    end else if (pend_q != 2'h0) begin
      pend_q <= pend_q - 2'h1;
      conv.valid <= (pend_q == 2'h1);  // One strobe per conversion
      conv.data  <= sample;
    end
  end
endmodule : acp_adc_model

// >>> adc_post_conversion_compute_tb.sv
// Self-checking bench of the post-conversion computation unit
module adc_post_conversion_compute_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic               aclk, aresetn, go, awvalid, wvalid, bready, arvalid, rready;
  logic               awready, wready, bvalid, arready, rvalid, pen, prdy, irq;
  logic [7:0]         awaddr, araddr, cnt;
  logic [31:0]        wdata, rdata, rdv;
  logic [1:0]         bresp, rresp, br, rr;
  logic [11:0]        smp;
  logic [17:0]        acc, filt;
  acp_pkg::acp_conv_t conv;
  acp_pkg::acp_trig_t trig;
  int                 miscompares, samples_checked;

  acp_core #(.PUMP_CYC(5)) uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .conv(conv),
    .start_evt(go), .trig(trig), .accumulator_value(acc), .sample_counter(cnt),
    .filter_output(filt), .pump_enable(pen), .pump_ready(prdy), .irq(irq));
  acp_adc_model adc (.aclk(aclk), .aresetn(aresetn), .go(go), .trig(trig), .sample(smp),
    .conv(conv));

  // Free-running clock
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  task complete_run;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run

  task tmo;
    miscompares++;
    complete_run();
  endtask : tmo

  // Register write: both channels offered, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic aw, w;
    aw = 1;
    w = 1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (aw && awready) begin
        aw = 0;
        awvalid <= 0;
      end
      if (w && wready) begin
        w = 0;
        wvalid <= 0;
      end
      if (bvalid) break;
    end
    if (n == 40) tmo();
    br = bresp;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    int n;
    logic ar;
    ar = 1;
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (ar && arready) begin
        ar = 0;
        arvalid <= 0;
      end
      if (rvalid) break;
    end
    if (n == 40) tmo();
    rdv = rdata;
    rr = rresp;
  endtask : rd

  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
    rd(a);
    chk(nm, e, rdv);
  endtask : rc

  // One conversion request, returning once its results are registered
  task automatic cv(input logic [11:0] s);
    int n;
    smp <= s;
    go <= 1;
    @(posedge aclk);
    go <= 0;
    for (n = 0; n < 20 && conv.valid !== 1'b1; n++) @(posedge aclk);
    if (n == 20) tmo();
    repeat (2) @(posedge aclk);
  endtask : cv

  // Clear command with a new control word, then wait its five-cycle bound
  task automatic clr(input logic [31:0] c);
    wr(8'h00, c | 32'h10);
    repeat (5) @(posedge aclk);
    chk("clr_acc", 0, {14'h0, acc});
    chk("clr_cnt", 0, {24'h0, cnt});
    rc(8'h00, c, "clr_bit");
    wr(8'h1C, 32'h3);
  endtask : clr

  // Reset values and unmapped address
  task t_regs;
    rc(8'h00, 0, "ctrl_rst");
    rc(8'h0C, 0, "stat_rst");
    rc(8'h20, 0, "imsk_rst");
    rc(8'h24, 0, "unmapped_rd");
    chk("rd_err", 2, {30'h0, rr});
    wr(8'h24, 32'h1);
    chk("wr_err", 2, {30'h0, br});
    $display("done regs");
  endtask : t_regs

  // Accumulate with shift, done interrupt, mask, saturation and overflow
  task t_accum;
    wr(8'h20, 32'h1);
    wr(8'h08, 32'h3FFFF);
    clr(32'h21);
    cv(12'h064);
    cv(12'h0C8);
    chk("acc_sum", 300, {14'h0, acc});
    chk("acc_cnt", 2, {24'h0, cnt});
    chk("acc_filt", 150, {14'h0, filt});
    chk("irq_on", 1, {31'h0, irq});
    wr(8'h1C, 32'h1);
    chk("irq_w1c", 0, {31'h0, irq});
    wr(8'h20, 32'h0);
    repeat (256) cv(12'hFFF);
    chk("irq_mask", 0, {31'h0, irq});
    chk("cnt_sat", 8'hFF, {24'h0, cnt});
    rc(8'h0C, 32'hFF01, "ovf_flag");
    rc(8'h1C, 32'h3, "ovf_thr");
    $display("done accumulate");
  endtask : t_accum

  // Basic mode leaves sums alone and tests every sample
  task t_basic;
    clr(32'h0);
    wr(8'h08, 32'h100);
    cv(12'h200);
    chk("basic_acc", 0, {14'h0, acc});
    chk("basic_cnt", 0, {24'h0, cnt});
    rc(8'h1C, 32'h3, "basic_thr");
    $display("done basic");
  endtask : t_basic

  // Average: test only at the target, restart clears on the next start
  task t_avg;
    wr(8'h04, 32'h2);
    wr(8'h08, 32'h0);
    clr(32'h2);
    cv(12'h005);
    rc(8'h1C, 32'h1, "avg_early");
    cv(12'h005);
    rc(8'h1C, 32'h3, "avg_test");
    cv(12'h005);
    chk("avg_restart", 5, {14'h0, acc});
    chk("avg_cnt", 1, {24'h0, cnt});
    $display("done average");
  endtask : t_avg

  // Burst: one start yields the whole burst, twice in a row
  task t_burst;
    int n;
    wr(8'h04, 32'h3);
    wr(8'h08, 32'h3FFFF);
    clr(32'h3);
    repeat (2) begin
      cv(12'h007);
      for (n = 0; n < 40 && cnt !== 8'h3; n++) @(posedge aclk);
      repeat (10) @(posedge aclk);
      chk("burst_cnt", 3, {24'h0, cnt});
      chk("burst_acc", 21, {14'h0, acc});
    end
    $display("done burst");
  endtask : t_burst

  // Filter step, then double sampling difference
  task t_lpf_ds;
    wr(8'h04, 32'h1);
    clr(32'h24);
    cv(12'h064);
    cv(12'h064);
    chk("lpf_acc", 150, {14'h0, acc});
    chk("lpf_filt", 75, {14'h0, filt});
    clr(32'h9);
    cv(12'h00A);
    cv(12'h032);
    chk("ds_acc", 40, {14'h0, acc});
    chk("ds_cnt", 1, {24'h0, cnt});
    $display("done filter and double sample");
  endtask : t_lpf_ds

  // Pump ready follows enable after the start-up count
  task t_pump;
    int n;
    wr(8'h00, 32'h100);
    for (n = 0; n < 20 && prdy !== 1'b1; n++) @(posedge aclk);
    chk("pump_en", 1, {31'h0, pen});
    chk("pump_wait", 1, {31'h0, n >= 3 && n <= 6});
    $display("done pump");
  endtask : t_pump

  // Reset, then the scenarios in turn
  initial begin
    miscompares = 0;
    samples_checked = 0;
    {aresetn, go, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, smp} = '0;
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    t_regs();
    t_accum();
    t_basic();
    t_avg();
    t_burst();
    t_lpf_ds();
    t_pump();
    complete_run();
  end
endmodule : adc_post_conversion_compute_tb
